// >>> pkg/rsc_defs.vh
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH

// clock
`define RSC_CLK_PERIOD_NS 5

// register offsets (4-bit address, 8-bit data)
`define RSC_ADDR_CAUSE 4'h0
`define RSC_ADDR_WDOG 4'h1
`define RSC_ADDR_OSC 4'h2
`define RSC_ADDR_DBG 4'h3
`define RSC_ADDR_PINCFG 4'h4
`define RSC_ADDR_SRCEN 4'h5

// reset cause register fields
`define RSC_CAUSE_EXT 0
`define RSC_CAUSE_POR 1
`define RSC_CAUSE_BROWN 2
`define RSC_CAUSE_WDOG 3

// watchdog control register fields
`define RSC_WDOG_SMR 0
`define RSC_WDOG_CFG_LO 4
`define RSC_WDOG_CFG_HI 7

// oscillator control register fields and reset value
`define RSC_OSC_IOSC_EN 0
`define RSC_OSC_XTAL_EN 1
`define RSC_OSC_SEL_XTAL 2
`define RSC_OSC_RESET 8'h0_1

// debugger control and pin config fields
`define RSC_DBG_RST 0
`define RSC_PIN_IND_EN 0

// external reset filter: lows needed for a sure reset
`define RSC_EXT_LOW_MIN 3'h4

// internal oscillator as a divided enable
`define RSC_IOSC_DIV 8'h2_4

// hold times on the reset pin after internal resets
`define RSC_POR_HOLD_NS 5000
`define RSC_POR_HOLD_CYC 13'h0_3e8
`define RSC_INT_HOLD_NS 2500
`define RSC_INT_HOLD_CYC 13'h0_1f4

// internal oscillator start-up time
`define RSC_OSC_START_NS 1000
`define RSC_OSC_START_CYC 13'h0_0c8

// stop recovery hold in oscillator cycles
`define RSC_SMR_HOLD_IOSC 13'h0_042
`define RSC_SMR_HOLD_XTAL 13'h1_388

// reset vector location
`define RSC_VEC_HI_ADDR 16'h0_002
`define RSC_VEC_LO_ADDR 16'h0_003

`endif

// >>> design/rsc_reset_stop_ctrl.v
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "rsc_defs.vh"

module rsc_reset_stop_ctrl #(
  parameter [12:0] SMR_HOLD_XTAL = `RSC_SMR_HOLD_XTAL
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_reset_n,
  // register port
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // shared reset pin
  input wire i_reset_pin,
  output reg o_reset_pin_out,
  output reg o_reset_pin_oe,
  // internal reset events
  input wire i_por_event,
  input wire i_brownout_event,
  input wire i_watchdog_event,
  // core and stop control
  input wire i_stop_exec,
  input wire [7:0] i_port_pins,
  output reg o_stop_mode,
  output reg o_sys_reset,
  output reg o_cpu_reset,
  // oscillator control
  output reg o_iosc_en,
  output reg o_xtal_en,
  output reg o_clk_sel_xtal,
  // reset vector fetch
  output reg o_pmem_rd,
  output reg [15:0] o_pmem_addr,
  input wire [7:0] i_pmem_data,
  output reg o_pc_load,
  output reg [15:0] o_pc_value
);

  // one-hot states
  localparam [7:0] ST_RUN = 8'h0_1;
  localparam [7:0] ST_RST = 8'h0_2;
  localparam [7:0] ST_STOP = 8'h0_4;
  localparam [7:0] ST_START = 8'h0_8;
  localparam [7:0] ST_HOLD = 8'h1_0;
  localparam [7:0] ST_VEC0 = 8'h2_0;
  localparam [7:0] ST_VEC1 = 8'h4_0;
  localparam [7:0] ST_VEC2 = 8'h8_0;

  reg [7:0] state; // current state
  reg [12:0] cnt; // shared down counter for hold phases
  reg [7:0] osc_div; // internal oscillator enable divider
  reg osc_tick; // one-cycle internal oscillator enable
  reg pin_s1; // first synchroniser stage, read only by pin_s2
  reg pin_s2; // synchronised reset pin level
  reg [2:0] low_cnt; // consecutive low samples
  reg oe_d1; // own drive delayed to match the sync path
  reg oe_d2;
  reg oe_d3;
  reg [7:0] port_s1; // port pin synchroniser, first stage
  reg [7:0] port_s2; // port pin synchroniser, second stage
  reg [7:0] port_prev; // previous synchronised port level
  reg [3:0] pend_cause; // causes latched at reset entry
  reg [3:0] cause; // reset cause register
  reg smr_flag; // watchdog control: stop recovery seen
  reg [3:0] wdog_cfg; // watchdog control: configuration
  reg [7:0] osc_ctl; // oscillator control register
  reg dbg_rst; // debugger reset request
  reg pin_ind_en; // reset pin drives during stop recovery
  reg [7:0] src_en; // stop recovery source enables
  reg xtal_hold; // crystal state captured at recovery start
  reg [7:0] vec_hi; // captured upper vector byte
  reg from_smr; // last entry to the vector fetch came from stop

  wire ext_low; // filtered external reset request
  wire ext_pin_low; // pin low and not our own drive
  wire [7:0] port_edge; // enabled port pin transitions
  wire int_rst; // internal reset source
  wire [3:0] new_cause; // cause bits of this cycle
  wire wr_cause; // write strobe to cause register
  wire wr_wdog; // write strobe to watchdog control

  // our drive echoes back through the sync path, so mask it
  assign ext_pin_low = !pin_s2 && !oe_d3 && !oe_d2 && !o_reset_pin_oe;
  // four lows in a row count as a reset; three may not
  assign ext_low = ext_pin_low && (low_cnt >= (`RSC_EXT_LOW_MIN - 3'h1));
  assign port_edge = (port_s2 ^ port_prev) & src_en;
  assign int_rst = i_por_event || i_brownout_event || i_watchdog_event || dbg_rst;
  assign new_cause = {i_watchdog_event, i_brownout_event, i_por_event || dbg_rst, ext_low};
  assign wr_cause = i_wr && (i_addr == `RSC_ADDR_CAUSE);
  assign wr_wdog = i_wr && (i_addr == `RSC_ADDR_WDOG);

  // synchronisers for the reset pin and port pins
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      port_s1 <= 8'h0_0;
      port_s2 <= 8'h0_0;
      port_prev <= 8'h0_0;
      oe_d1 <= 1'b0;
      oe_d2 <= 1'b0;
      oe_d3 <= 1'b0;
    end else begin
      pin_s1 <= i_reset_pin;
      pin_s2 <= pin_s1;
      port_s1 <= i_port_pins;
      port_s2 <= port_s1;
      port_prev <= port_s2;
      oe_d1 <= o_reset_pin_oe;
      oe_d2 <= oe_d1;
      oe_d3 <= oe_d2;
    end
  end

  // low-time counter on the synchronised pin
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_cnt <= 3'h0;
    end else if (!ext_pin_low) begin
      low_cnt <= 3'h0;
    end else if (low_cnt != 3'h7) begin
      low_cnt <= low_cnt + 3'h1;
    end
  end

  // internal oscillator enable; stopped in stop like the real clock
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      osc_div <= 8'h0_0;
      osc_tick <= 1'b0;
    end else if (state == ST_STOP || (state == ST_START && cnt == 13'h0_000)) begin
      // restart at hold entry so the hold counts whole oscillator cycles
      osc_div <= 8'h0_0;
      osc_tick <= 1'b0;
    end else if (osc_div == (`RSC_IOSC_DIV - 8'h0_1)) begin
      osc_div <= 8'h0_0;
      osc_tick <= 1'b1;
    end else begin
      osc_div <= osc_div + 8'h0_1;
      osc_tick <= 1'b0;
    end
  end

  // main sequencer
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= ST_RST;
      cnt <= `RSC_POR_HOLD_CYC;
      pend_cause <= 4'h2;
      xtal_hold <= 1'b0;
      vec_hi <= 8'h0_0;
      o_pmem_rd <= 1'b0;
      o_pmem_addr <= 16'h0_000;
      o_pc_load <= 1'b0;
      o_pc_value <= 16'h0_000;
    end else begin
      o_pc_load <= 1'b0;
      if (state != ST_RST && (ext_low || int_rst)) begin
        // any reset source aborts whatever runs
        state <= ST_RST;
        pend_cause <= new_cause;
        o_pmem_rd <= 1'b0;
        if (i_por_event || dbg_rst) begin
          cnt <= `RSC_POR_HOLD_CYC;
        end else begin
          cnt <= `RSC_INT_HOLD_CYC;
        end
      end else begin
        case (state)
          ST_RUN: begin
            if (i_stop_exec) begin
              state <= ST_STOP;
            end
          end
          ST_RST: begin
            pend_cause <= pend_cause | new_cause;
            if (cnt != 13'h0_000) begin
              cnt <= cnt - 13'h0_001;
            end else if (!pin_s2 || o_reset_pin_oe || oe_d3) begin
              // pin still low, or our own release not yet through the sync path
              state <= ST_RST;
            end else begin
              state <= ST_VEC0;
              o_pmem_rd <= 1'b1;
              o_pmem_addr <= `RSC_VEC_HI_ADDR;
            end
          end
          ST_STOP: begin
            if (port_edge != 8'h0_0) begin
              state <= ST_START;
              xtal_hold <= osc_ctl[`RSC_OSC_XTAL_EN];
              cnt <= `RSC_OSC_START_CYC;
            end
          end
          ST_START: begin
            if (cnt != 13'h0_000) begin
              cnt <= cnt - 13'h0_001;
            end else begin
              state <= ST_HOLD;
              cnt <= xtal_hold ? SMR_HOLD_XTAL : `RSC_SMR_HOLD_IOSC;
            end
          end
          ST_HOLD: begin
            if (cnt == 13'h0_000) begin
              state <= ST_VEC0;
              o_pmem_rd <= 1'b1;
              o_pmem_addr <= `RSC_VEC_HI_ADDR;
            end else if (osc_tick) begin
              cnt <= cnt - 13'h0_001;
            end
          end
          ST_VEC0: begin
            state <= ST_VEC1;
            o_pmem_addr <= `RSC_VEC_LO_ADDR;
          end
          ST_VEC1: begin
            state <= ST_VEC2;
            vec_hi <= i_pmem_data;
          end
          ST_VEC2: begin
            state <= ST_RUN;
            o_pmem_rd <= 1'b0;
            o_pc_value <= {vec_hi, i_pmem_data};
            o_pc_load <= 1'b1;
          end
          default: begin
            state <= ST_RST;
            cnt <= `RSC_POR_HOLD_CYC;
          end
        endcase
      end
    end
  end

  // registered outputs derived from the state
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sys_reset <= 1'b1;
      o_cpu_reset <= 1'b1;
      o_stop_mode <= 1'b0;
      o_reset_pin_out <= 1'b0;
      o_reset_pin_oe <= 1'b1;
    end else begin
      o_reset_pin_out <= 1'b0;
      o_sys_reset <= (state == ST_RST);
      o_cpu_reset <= (state != ST_RUN) && (state != ST_STOP);
      o_stop_mode <= (state == ST_STOP);
      // open drain: only ever pull low, during the reset hold count and, with pin_ind_en, in stop recovery
      if (state == ST_RST) begin
        o_reset_pin_oe <= (cnt != 13'h0_000);
      end else begin
        o_reset_pin_oe <= pin_ind_en && ((state == ST_START) || (state == ST_HOLD));
      end
    end
  end

  // reset cause register: set wins over write-one-to-clear
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cause <= 4'h0;
    end else begin
      // recovery runs through vec0 too; only resets publish causes
      if (state == ST_VEC0 && o_pmem_addr == `RSC_VEC_HI_ADDR && !from_smr) begin
        cause <= (cause & ~(wr_cause ? i_wdata[3:0] : 4'h0)) | pend_cause;
      end else if (wr_cause) begin
        cause <= cause & ~i_wdata[3:0];
      end
    end
  end

  // remember where the vector fetch was entered from
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      from_smr <= 1'b0;
    end else if (state == ST_HOLD) begin
      from_smr <= 1'b1;
    end else if (state == ST_RST) begin
      from_smr <= 1'b0;
    end
  end

  // watchdog and oscillator control: the only ones recovery touches
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      smr_flag <= 1'b0;
      wdog_cfg <= 4'h0;
      osc_ctl <= `RSC_OSC_RESET;
    end else if (state == ST_RST) begin
      smr_flag <= 1'b0;
      wdog_cfg <= 4'h0;
      osc_ctl <= `RSC_OSC_RESET;
    end else if (state == ST_STOP && port_edge != 8'h0_0) begin
      smr_flag <= 1'b1;
      // back on the internal oscillator; crystal choice stays
      osc_ctl[`RSC_OSC_IOSC_EN] <= 1'b1;
      osc_ctl[`RSC_OSC_SEL_XTAL] <= 1'b0;
    end else begin
      if (wr_wdog) begin
        wdog_cfg <= i_wdata[`RSC_WDOG_CFG_HI:`RSC_WDOG_CFG_LO];
        if (i_wdata[`RSC_WDOG_SMR]) begin
          smr_flag <= 1'b0;
        end
      end
      if (i_wr && i_addr == `RSC_ADDR_OSC) begin
        osc_ctl <= i_wdata;
      end
    end
  end

  // debugger request: cleared by system reset, so it clears itself in the reset it asks for
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dbg_rst <= 1'b0;
    end else if (state == ST_RST) begin
      dbg_rst <= 1'b0;
    end else if (i_wr && i_addr == `RSC_ADDR_DBG) begin
      dbg_rst <= i_wdata[`RSC_DBG_RST];
    end
  end

  // pin config and recovery sources, cleared by system reset
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_ind_en <= 1'b0;
      src_en <= 8'h0_0;
    end else if (state == ST_RST) begin
      pin_ind_en <= 1'b0;
      src_en <= 8'h0_0;
    end else begin
      if (i_wr && i_addr == `RSC_ADDR_PINCFG) begin
        pin_ind_en <= i_wdata[`RSC_PIN_IND_EN];
      end
      if (i_wr && i_addr == `RSC_ADDR_SRCEN) begin
        src_en <= i_wdata;
      end
    end
  end

  // oscillator control pins follow the register
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_iosc_en <= 1'b1;
      o_xtal_en <= 1'b0;
      o_clk_sel_xtal <= 1'b0;
    end else begin
      // stop halts both oscillators
      o_iosc_en <= osc_ctl[`RSC_OSC_IOSC_EN] && (state != ST_STOP);
      o_xtal_en <= osc_ctl[`RSC_OSC_XTAL_EN] && (state != ST_STOP);
      o_clk_sel_xtal <= osc_ctl[`RSC_OSC_SEL_XTAL];
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h0_0;
    end else if (i_rd) begin
      case (i_addr)
        `RSC_ADDR_CAUSE: o_rdata <= {4'h0, cause};
        `RSC_ADDR_WDOG: o_rdata <= {wdog_cfg, 3'h0, smr_flag};
        `RSC_ADDR_OSC: o_rdata <= osc_ctl;
        `RSC_ADDR_DBG: o_rdata <= {7'h00, dbg_rst};
        `RSC_ADDR_PINCFG: o_rdata <= {7'h00, pin_ind_en};
        `RSC_ADDR_SRCEN: o_rdata <= src_en;
        default: o_rdata <= 8'h0_0;
      endcase
    end else begin
      o_rdata <= 8'h0_0;
    end
  end

endmodule // rsc_reset_stop_ctrl

// >>> verification/rsc_pin_partner.sv
`timescale 1ns/1ps
module rsc_pin_partner (
  // clock
  input wire i_ref_clk,
  // our device's drive, high pulls the line low
  input wire i_dev_oe,
  // resolved level of the shared line
  output wire o_pin
);
  int cnt = 0; // edges this board part still holds the line low
  // count down one per edge, so the line is let go on its own
  always @(posedge i_ref_clk) if (cnt != 0) cnt <= cnt - 1;
  // wired line with a pull-up: idles high, any driver wins low
  assign o_pin = !(cnt != 0 || i_dev_oe);
  // hold the line low for n edges; called just after an edge
  task automatic pull(input int n);
    cnt <= n;
  endtask
endmodule // rsc_pin_partner

// >>> verification/rsc_reset_stop_ctrl_chk.sv
`timescale 1ns/1ps
module rsc_reset_stop_ctrl_chk #(
  parameter [12:0] SMR_HOLD_XTAL = 13'h1388
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_reset_n,
  // pin, core and oscillator
  input wire i_reset_pin,
  input wire o_reset_pin_oe,
  input wire i_stop_exec,
  input wire o_stop_mode,
  input wire o_sys_reset,
  input wire o_cpu_reset,
  input wire o_iosc_en,
  input wire o_clk_sel_xtal,
  // vector fetch
  input wire o_pmem_rd,
  input wire [15:0] o_pmem_addr,
  input wire o_pc_load
);
  // recovery window: tick phase is unknown, so one tick of slack
  localparam int LO = 65 * 36;
  localparam int HI = 280 + 36 * (SMR_HOLD_XTAL > 66 ? SMR_HOLD_XTAL : 66);
  logic [3:0] quiet; // cycles since our own drive or reset ended
  logic [12:0] hold_len; // cycles of cpu hold outside stop and reset
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  // our own drive echoes on the pin, so lows count only once quiet
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) quiet <= 4'h0;
    else if (o_reset_pin_oe || o_sys_reset) quiet <= 4'h0;
    else if (quiet != 4'hf) quiet <= quiet + 4'h1;
  end
  // length of the cpu hold after a recovery
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) hold_len <= 13'h0;
    else if (o_cpu_reset && !o_sys_reset && !o_stop_mode) hold_len <= hold_len + 13'h1;
    else hold_len <= 13'h0;
  end
  property p_pulse;
    (!i_reset_pin && quiet >= 4'h8) [*4] |-> ##[0:5] o_sys_reset;
  endproperty
  a_pulse: assert property (p_pulse) else $error("low pulse gave no reset");
  property p_held;
    o_sys_reset && !i_reset_pin |=> o_sys_reset;
  endproperty
  a_held: assert property (p_held) else $error("left reset with pin low");
  property p_exit;
    $rose(i_reset_pin) && o_sys_reset |-> ##[1:10] !o_sys_reset;
  endproperty
  a_exit: assert property (p_exit) else $error("reset not left after release");
  property p_drive;
    $rose(o_sys_reset) |-> ##[0:2] o_reset_pin_oe;
  endproperty
  a_drive: assert property (p_drive) else $error("pin not driven in reset");
  property p_keep;
    $rose(o_reset_pin_oe) |=> o_reset_pin_oe [*8];
  endproperty
  a_keep: assert property (p_keep) else $error("pin drive too short");
  property p_stop;
    $rose(o_stop_mode) |-> $past(i_stop_exec, 1) || $past(i_stop_exec, 2);
  endproperty
  a_stop: assert property (p_stop) else $error("stop without instruction");
  property p_hold;
    o_pc_load && hold_len > 13'h10 |-> hold_len >= LO && hold_len <= HI;
  endproperty
  a_hold: assert property (p_hold) else $error("recovery hold length wrong");
  property p_osc;
    o_pc_load && hold_len > 13'h10 |-> o_iosc_en && !o_clk_sel_xtal;
  endproperty
  a_osc: assert property (p_osc) else $error("internal clock not selected");
  property p_fetch;
    $rose(o_pmem_rd) |-> o_pmem_addr == 16'h2 ##1 o_pmem_addr == 16'h3 ##[1:3] o_pc_load;
  endproperty
  a_fetch: assert property (p_fetch) else $error("vector fetch order wrong");
  property p_run;
    o_pc_load |=> !o_cpu_reset;
  endproperty
  a_run: assert property (p_run) else $error("cpu held after vector load");
endmodule // rsc_reset_stop_ctrl_chk

// >>> verification/rsc_reset_stop_ctrl_tb.sv
`timescale 1ns/1ps
module rsc_reset_stop_ctrl_tb;
  // clock, reset and register port
  logic i_ref_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  wire [7:0] o_rdata;
  // reset line, events, stop and memory
  wire pin;
  wire oe;
  logic [2:0] evt = 3'h0; // por, watchdog, brownout
  wire xtal_en;
  wire pout;
  logic i_stop_exec = 1'b0;
  logic [7:0] i_port_pins = 8'h0;
  logic [7:0] i_pmem_data = 8'h0;
  wire o_stop_mode;
  wire o_sys_reset;
  wire o_cpu_reset;
  wire o_iosc_en;
  wire o_clk_sel_xtal;
  wire o_pmem_rd;
  wire o_pc_load;
  wire [15:0] o_pmem_addr;
  wire [15:0] o_pc_value;
  int miscompares = 0;
  int n_checks = 0;
  int n;
  int t;
  logic [7:0] rv;
  // rows: write flag, address, write data, read-back
  logic [20:0] rows [0:4] = '{{1'b0, 4'h2, 8'h00, 8'h01}, {1'b1, 4'h5, 8'ha5, 8'ha5},
    {1'b1, 4'h4, 8'h01, 8'h01}, {1'b1, 4'h1, 8'hf0, 8'hf0}, {1'b1, 4'hf, 8'hff, 8'h00}};
  // short crystal hold keeps the run brief
  rsc_reset_stop_ctrl #(.SMR_HOLD_XTAL(13'h50)) dut (
    .i_ref_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_reset_pin(pin), .o_reset_pin_out(pout), .o_reset_pin_oe(oe),
    .i_por_event(evt[2]), .i_brownout_event(evt[0]), .i_watchdog_event(evt[1]),
    .i_stop_exec, .i_port_pins, .o_stop_mode, .o_sys_reset, .o_cpu_reset,
    .o_iosc_en, .o_xtal_en(xtal_en), .o_clk_sel_xtal, .o_pmem_rd, .o_pmem_addr,
    .i_pmem_data, .o_pc_load, .o_pc_value);
  rsc_pin_partner part (.i_ref_clk, .i_dev_oe(oe), .o_pin(pin));
  // 200 MHz clock
  always #2.5 i_ref_clk = ~i_ref_clk;
  // program memory answers one cycle after the address; other bytes vary
  always @(posedge i_ref_clk) begin
    i_pmem_data <= o_pmem_addr == 16'h2 ? 8'h12 : o_pmem_addr == 16'h3 ? 8'h34 : ~o_pmem_addr[7:0];
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e, input string nm);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask
  // step past an edge so its updates have landed
  task automatic tick();
    @(posedge i_ref_clk);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    tick();
    i_wr <= 1'b0;
    tick();
  endtask
  task automatic rd_reg(input logic [3:0] a);
    i_addr <= a;
    i_rd <= 1'b1;
    tick();
    i_rd <= 1'b0;
    rv = o_rdata;
    tick();
  endtask
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // count cycles until the vector is loaded, bounded
  task automatic wait_load(input int lim);
    n = 0;
    while (o_pc_load !== 1'b1 && n < lim) begin
      tick();
      n++;
    end
    if (n >= lim) begin
      miscompares++;
      $display("unexpected vector load wait: expected below %0d, seen %0d", lim, n);
      stop_test();
    end
  endtask
  initial begin
    repeat (8) tick();
    i_reset_n <= 1'b1;
    wait_load(3000);
    chk(o_pc_value, 16'h1234, "vector");
    rd_reg(4'h0);
    chk({8'h0, rv}, 16'h2, "cause");
    wr_reg(4'h0, 8'h0f);
    foreach (rows[i]) begin
      if (rows[i][20]) wr_reg(rows[i][19:16], rows[i][15:8]);
      rd_reg(rows[i][19:16]);
      chk({8'h0, rv}, {8'h0, rows[i][7:0]}, "register");
    end
    // shortest sure pulse from another board part
    part.pull(4);
    repeat (8) tick();
    chk({15'h0, o_sys_reset}, 16'h1, "reset");
    chk({15'h0, oe}, 16'h1, "pin drive");
    chk({15'h0, pout}, 16'h0, "pin out level");
    wait_load(1000);
    rd_reg(4'h0);
    chk({8'h0, rv}, 16'h1, "cause");
    // line held past the internal hold
    part.pull(700);
    repeat (650) tick();
    chk({15'h0, o_sys_reset}, 16'h1, "held reset");
    wait_load(100);
    chk({15'h0, n >= 50 && n <= 62}, 16'h1, "exit delay");
    wr_reg(4'h0, 8'h0f);
    // brownout, watchdog, then power-on event
    for (int k = 0; k < 3; k++) begin
      t = (k == 2) ? 1000 : 500;
      evt <= 3'h1 << k;
      tick();
      evt <= 3'h0;
      repeat (3) tick();
      chk({15'h0, oe}, 16'h1, "pin drive");
      n = 0;
      while (oe === 1'b1 && n < 2000) begin
        tick();
        n++;
      end
      chk({15'h0, n >= t - 10 && n <= t + 5}, 16'h1, "drive length");
      wait_load(100);
      rd_reg(4'h0);
      chk({8'h0, rv}, (k == 2) ? 16'h2 : 16'h4 << k, "cause");
      wr_reg(4'h0, 8'h0f);
    end
    // debugger request
    wr_reg(4'h3, 8'h01);
    repeat (4) tick();
    chk({15'h0, o_sys_reset}, 16'h1, "debug reset");
    wait_load(3000);
    rd_reg(4'h3);
    chk({8'h0, rv}, 16'h0, "debug request");
    rd_reg(4'h0);
    chk({8'h0, rv}, 16'h2, "cause");
    wr_reg(4'h0, 8'h0f);
    // stop and recovery, internal clock then crystal enabled
    for (int k = 0; k < 2; k++) begin
      wr_reg(4'h5, 8'h01);
      wr_reg(4'h2, k ? 8'h07 : 8'h01);
      i_stop_exec <= 1'b1;
      tick();
      i_stop_exec <= 1'b0;
      repeat (3) tick();
      chk({15'h0, o_stop_mode}, 16'h1, "stop");
      i_port_pins[1] <= ~i_port_pins[1];
      repeat (10) tick();
      chk({15'h0, o_stop_mode}, 16'h1, "stop kept");
      i_port_pins[0] <= ~i_port_pins[0];
      wait_load(4000);
      t = 200 + 36 * (k ? 80 : 66);
      chk({15'h0, n >= t - 5 && n <= t + 45}, 16'h1, "recovery time");
      chk({14'h0, o_iosc_en, o_clk_sel_xtal}, 16'h2, "clock select");
      chk({15'h0, xtal_en}, k ? 16'h1 : 16'h0, "crystal kept");
      rd_reg(4'h5);
      chk({8'h0, rv}, 16'h1, "source enables");
      rd_reg(4'h0);
      chk({8'h0, rv}, 16'h0, "cause");
    end
    stop_test();
  end
endmodule // rsc_reset_stop_ctrl_tb
bind rsc_reset_stop_ctrl rsc_reset_stop_ctrl_chk #(.SMR_HOLD_XTAL(SMR_HOLD_XTAL)) u_chk (
  .i_ref_clk, .i_reset_n, .i_reset_pin, .o_reset_pin_oe, .i_stop_exec, .o_stop_mode,
  .o_sys_reset, .o_cpu_reset, .o_iosc_en, .o_clk_sel_xtal, .o_pmem_rd, .o_pmem_addr,
  .o_pc_load);
